// ---- core/ptt_pkg.sv ----
// Purpose: shared constants for the power transfer termination block
// Assumes: comparator results arrive as one vector of raw pin levels
// Notes:   offsets are byte addresses on a 32-bit apb bus
package ptt_pkg;
  localparam int NCOND = 13;
  localparam int CB_AD = 0;      // adapter above enable threshold
  localparam int CB_CTRL_HI = 1; // temp_control_input above 1.4 V
  localparam int CB_JHOT = 2;    // junction above 150 C
  localparam int CB_RLOW = 3;    // limit_resistance below 215 ohm
  localparam int CB_TSHOT = 4;   // temp_sense_input past hot_threshold
  localparam int CB_CTRL_LO = 5; // temp_control_input below 100 mV
  localparam int CB_TERM = 6;    // termination sense above current_limit_sense
  localparam int CB_TFIT = 7;    // termination resistor fitted
  localparam int CB_LSEL = 8;    // limit_select_input above 1.4 V
  localparam int CB_PMEM = 9;    // ping_memory above 1.6 V
  localparam int CB_RECTIFIER_NODE = 10;   // rectifier_node target reached
  localparam int CB_I100 = 11;   // output current above 100 mA
  localparam int CB_I400 = 12;   // output current above 400 mA
  localparam int NREASON = 6;
  localparam int RS_AD = 0;
  localparam int RS_CHG = 1;
  localparam int RS_FLT = 2;
  localparam int RS_HOT = 3;
  localparam int RS_OV = 4;
  localparam int RS_TERM = 5;
  localparam logic [7:0] CODE_UNKNOWN = 8'h00;
  localparam logic [7:0] CODE_CHG = 8'h01;
  localparam logic [7:0] CODE_FAULT = 8'h02;
  localparam logic [7:0] CODE_OTEMP = 8'h03;
  localparam logic [7:0] CODE_OVOLT = 8'h04;
  localparam logic [7:0] CODE_MAX_SENT = 8'h04;
  localparam logic [6:0] ERR_PKT_LIMIT = 7'h40;
  localparam logic [1:0] LIM_NONE = 2'h0;
  localparam logic [1:0] LIM_PLUS = 2'h1;
  localparam logic [1:0] LIM_MINUS = 2'h2;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LAST = 8'h08;
  localparam logic [7:0] OFF_ERRLIM = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_START = 7'h02, ST_ACTIVE = 7'h04, ST_OFF = 7'h08,
    ST_SEND = 7'h10, ST_ADAPT = 7'h20, ST_HALT = 7'h40
  } ptt_state_e;
endpackage : ptt_pkg

// ---- core/ptt_cond_if.sv ----
// Purpose: carries raw and synchronised comparator levels
// Assumes: raw levels are asynchronous to clk_sys
// Notes:   one bundle, two views
`timescale 1ns/1ps
`default_nettype none
interface ptt_cond_if;
  logic [ptt_pkg::NCOND-1:0] raw;
  logic [ptt_pkg::NCOND-1:0] sync;
  modport syncer (input raw, output sync);
  modport user (output raw, input sync);
endinterface : ptt_cond_if
`default_nettype wire

// ---- core/ptt_sync.sv ----
// Purpose: two-flop synchroniser for the comparator vector
// Assumes: single clock clk_sys
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ptt_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  ptt_cond_if.syncer cond
);
  logic [ptt_pkg::NCOND-1:0] meta_q;
  logic [ptt_pkg::NCOND-1:0] sync_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= cond.raw;
      sync_q <= meta_q;
    end
  end

  assign cond.sync = sync_q;
endmodule : ptt_sync
`default_nettype wire

// ---- core/ptt_once.sv ----
// Purpose: one message per detected condition
// Assumes: take is a pulse when a message for that condition is accepted
// Notes:   re-arms only after the condition has gone away
`timescale 1ns/1ps
`default_nettype none
module ptt_once #(
  parameter int W = 6
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] cond,
  input  wire logic [W-1:0] take,
  output logic      [W-1:0] pend
);
  logic [W-1:0] sent_q;

  // clear wins: take sets the bit only while cond is high
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sent_q <= '0;
    else
      sent_q <= cond & (sent_q | take);
  end

  assign pend = cond & ~sent_q;
endmodule : ptt_once
`default_nettype wire

// ---- core/ptt_top.sv ----
// Purpose: decides when to end wireless power transfer and what to send
// Assumes: analog comparators give digital levels; a message engine takes term_* by valid/ready
// Notes:   apb registers: run control, status, last message, error packet limit
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ptt_top #(
  parameter int CNT_W = 16
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [31:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [ptt_pkg::NCOND-1:0] cond_raw,
  input  wire logic                      mode_pma,
  input  wire logic                      comm_active,
  input  wire logic                      err_pkt,
  output logic                           term_valid,
  input  wire logic                      term_ready,
  output logic      [7:0]                term_code,
  output logic                           term_eoc,
  output logic                           output_en,
  output logic                           adapter_switch_en,
  output logic                           comm_limit_en,
  output logic      [1:0]                comm_limit_sel,
  output logic                           pad_detect_n_o,
  output logic                           pad_detect_n_oe,
  output logic                           boost_mode,
  output logic                           adapter_status_out
);
  ptt_cond_if cif ();
  ptt_pkg::ptt_state_e       state_q;
  logic [ptt_pkg::NCOND-1:0] cs;
  logic [ptt_pkg::NREASON-1:0] cond;
  logic [ptt_pkg::NREASON-1:0] pend;
  logic [ptt_pkg::NREASON-1:0] take;
  logic [2:0]                pick;
  logic                      any_pend;
  logic                      run_q;
  logic [6:0]                errlim_q;
  logic [6:0]                errcnt_q;
  logic                      ov_q;
  logic                      mode_q;
  logic [2:0]                reason_q;
  logic [7:0]                code_q;
  logic                      eoc_q;
  logic [CNT_W-1:0]          msgcnt_q;
  logic                      out_en_q;
  logic                      sw_en_q;
  logic                      lim_en_q;
  logic [1:0]                lim_sel_q;
  logic                      pd_oe_q;
  logic                      boost_q;
  logic                      adst_q;
  logic [7:0]                code_d;
  logic                      wr;
  logic                      rd;

  assign cif.raw = cond_raw;
  ptt_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cond    (cif.syncer)
  );
  assign cs = cif.sync;

  // reason conditions, lowest index is the lowest code
  always_comb
  begin
    cond = '0;
    cond[ptt_pkg::RS_AD] = cs[ptt_pkg::CB_AD];
    cond[ptt_pkg::RS_CHG] = cs[ptt_pkg::CB_CTRL_HI];
    cond[ptt_pkg::RS_FLT] = cs[ptt_pkg::CB_JHOT] | cs[ptt_pkg::CB_RLOW];
    cond[ptt_pkg::RS_HOT] = cs[ptt_pkg::CB_TSHOT] | cs[ptt_pkg::CB_CTRL_LO];
    cond[ptt_pkg::RS_OV] = ov_q;
    // termination sense only counts with a second-standard transmitter
    cond[ptt_pkg::RS_TERM] = mode_q & cs[ptt_pkg::CB_TFIT] & cs[ptt_pkg::CB_TERM];
  end

  ptt_once #(
    .W (ptt_pkg::NREASON)
  ) u_once (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cond    (cond),
    .take    (take),
    .pend    (pend)
  );

  // priority pick of the lowest pending reason
  always_comb
  begin
    pick = 3'h0;
    any_pend = |pend;
    for (int i = ptt_pkg::NREASON - 1; i >= 0; i--)
    begin
      if (pend[i])
        pick = 3'(i);
    end
  end

  always_comb
  begin
    case (pick)
      3'h0: code_d = ptt_pkg::CODE_UNKNOWN;
      3'h2: code_d = ptt_pkg::CODE_FAULT;
      3'h3: code_d = ptt_pkg::CODE_OTEMP;
      3'h4: code_d = ptt_pkg::CODE_OVOLT;
      default: code_d = ptt_pkg::CODE_CHG;
    endcase
  end

  assign take = (state_q == ptt_pkg::ST_SEND && term_ready) ?
                ptt_pkg::NREASON'(1) << reason_q : '0;

  // apb slave, zero wait states
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      run_q <= ptt_pkg::CTRL_RST[0];
      errlim_q <= ptt_pkg::ERR_PKT_LIMIT;
    end
    else if (wr && paddr[7:0] == ptt_pkg::OFF_CTRL)
      run_q <= pwdata[0];
    else if (wr && paddr[7:0] == ptt_pkg::OFF_ERRLIM)
      errlim_q <= pwdata[6:0];
  end

  always_comb
  begin
    prdata = '0;
    pslverr = 1'b0;
    if (paddr[31:8] != '0)
      pslverr = psel & penable;
    else if (paddr[7:0] == ptt_pkg::OFF_CTRL)
      prdata[0] = run_q;
    else if (paddr[7:0] == ptt_pkg::OFF_STATUS)
      prdata = {9'h000, state_q, 2'h0, mode_q, cs};
    else if (paddr[7:0] == ptt_pkg::OFF_LAST)
      prdata = {16'(msgcnt_q), 7'h00, eoc_q, code_q};
    else if (paddr[7:0] == ptt_pkg::OFF_ERRLIM)
      prdata[6:0] = errlim_q;
    else
      pslverr = psel & penable;
    if (!rd)
      prdata = '0;
  end

  // mode is from the protocol detector on the same clock
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_q <= 1'b0;
    else
      mode_q <= mode_pma;
  end

  // startup error packet counter; ov sets only in startup, clears in idle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      errcnt_q <= '0;
      ov_q <= 1'b0;
    end
    else if (state_q == ptt_pkg::ST_IDLE)
    begin
      errcnt_q <= '0;
      ov_q <= 1'b0;
    end
    else if (state_q == ptt_pkg::ST_START && err_pkt && !ov_q)
    begin
      errcnt_q <= errcnt_q + 7'h01;
      if (errcnt_q + 7'h01 >= errlim_q)
        ov_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= ptt_pkg::ST_IDLE;
    else if (!run_q && state_q != ptt_pkg::ST_SEND)
      state_q <= ptt_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        ptt_pkg::ST_IDLE:
          state_q <= ptt_pkg::ST_START;
        ptt_pkg::ST_START:
          if (any_pend)
            state_q <= ptt_pkg::ST_OFF;
          else if (cs[ptt_pkg::CB_RECTIFIER_NODE])
            state_q <= ptt_pkg::ST_ACTIVE;
        ptt_pkg::ST_ACTIVE:
          if (any_pend)
            state_q <= ptt_pkg::ST_OFF;
        ptt_pkg::ST_OFF:
          state_q <= ptt_pkg::ST_SEND;
        ptt_pkg::ST_SEND:
          if (term_ready)
            state_q <= (reason_q == 3'(ptt_pkg::RS_AD)) ? ptt_pkg::ST_ADAPT : ptt_pkg::ST_HALT;
        ptt_pkg::ST_ADAPT:
          if (!cs[ptt_pkg::CB_AD])
            state_q <= ptt_pkg::ST_IDLE;
        ptt_pkg::ST_HALT:
          if (cond == '0)
            state_q <= ptt_pkg::ST_IDLE;
        default:
          state_q <= ptt_pkg::ST_IDLE;
      endcase
    end
  end

  // message latched while the output is already off
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reason_q <= '0;
      code_q <= '0;
      eoc_q <= 1'b0;
    end
    else if (state_q == ptt_pkg::ST_OFF)
    begin
      reason_q <= pick;
      code_q <= code_d;
      eoc_q <= mode_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      msgcnt_q <= '0;
    else if (state_q == ptt_pkg::ST_SEND && term_ready)
      msgcnt_q <= msgcnt_q + CNT_W'(1);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_en_q <= 1'b0;
      sw_en_q <= 1'b0;
    end
    else
    begin
      out_en_q <= (state_q == ptt_pkg::ST_ACTIVE) && !any_pend && run_q;
      // switch only after the adapter message has gone out
      sw_en_q <= (state_q == ptt_pkg::ST_ADAPT) && cs[ptt_pkg::CB_AD] && run_q;
    end
  end

  // pin function outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      lim_en_q <= 1'b1;
      lim_sel_q <= ptt_pkg::LIM_NONE;
      pd_oe_q <= 1'b0;
      boost_q <= 1'b0;
      adst_q <= 1'b0;
    end
    else
    begin
      // floating pin reads low through the pulldown, so limiting stays on
      lim_en_q <= !cs[ptt_pkg::CB_LSEL];
      if (mode_q || !comm_active || cs[ptt_pkg::CB_LSEL] || !cs[ptt_pkg::CB_I100])
        lim_sel_q <= ptt_pkg::LIM_NONE;
      else if (!cs[ptt_pkg::CB_I400])
        lim_sel_q <= ptt_pkg::LIM_PLUS;
      else
        lim_sel_q <= ptt_pkg::LIM_MINUS;
      pd_oe_q <= !mode_q && cs[ptt_pkg::CB_PMEM];
      boost_q <= cs[ptt_pkg::CB_TFIT];
      adst_q <= !cs[ptt_pkg::CB_TFIT] && cs[ptt_pkg::CB_AD];
    end
  end

  assign term_valid = (state_q == ptt_pkg::ST_SEND);
  assign term_code = code_q;
  assign term_eoc = eoc_q;
  assign output_en = out_en_q;
  assign adapter_switch_en = sw_en_q;
  assign comm_limit_en = lim_en_q;
  assign comm_limit_sel = lim_sel_q;
  assign pad_detect_n_o = 1'b0;
  assign pad_detect_n_oe = pd_oe_q;
  assign boost_mode = boost_q;
  assign adapter_status_out = adst_q;

  // checks
  a_code_range: assert property (@(posedge clk_sys) disable iff (rst)
    term_valid |-> term_code <= ptt_pkg::CODE_MAX_SENT) else $error("reserved code sent");
  a_off_before_msg: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(term_valid) |-> !output_en && $past(!output_en)) else $error("output on at message");
  a_switch_after_msg: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(adapter_switch_en) |-> $past(term_code, 2) == ptt_pkg::CODE_UNKNOWN && !output_en)
    else $error("switch without adapter message");
  a_msg_held: assert property (@(posedge clk_sys) disable iff (rst)
    term_valid && !term_ready |=> term_valid && $stable(term_code) && $stable(term_eoc))
    else $error("message dropped before taken");
  a_kind_by_mode: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(term_valid) |-> term_eoc == $past(mode_q)) else $error("wrong message kind");
  a_ov_timeout: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ov_q) && !(|pend[3:0]) && run_q |-> ##[1:3] term_valid && term_code == ptt_pkg::CODE_OVOLT)
    else $error("timeout not reported");
  a_lim_select: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 comm_limit_en == !$past(cs[ptt_pkg::CB_LSEL])) else $error("limit enable wrong");
  a_lim_pma_none: assert property (@(posedge clk_sys) disable iff (rst)
    mode_q ##1 mode_q |-> comm_limit_sel == ptt_pkg::LIM_NONE) else $error("limit in second standard");
  a_pad_detect: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 pad_detect_n_oe == ($past(cs[ptt_pkg::CB_PMEM]) && !$past(mode_q))) else $error("pad detect wrong");
  a_boost_select: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 boost_mode == $past(cs[ptt_pkg::CB_TFIT])) else $error("boost select wrong");
  c_adapter: cover property (@(posedge clk_sys) disable iff (rst) $rose(adapter_switch_en));
  c_ov: cover property (@(posedge clk_sys) disable iff (rst) term_valid && term_code == ptt_pkg::CODE_OVOLT);
  c_term_eoc: cover property (@(posedge clk_sys) disable iff (rst) term_valid && reason_q == 3'(ptt_pkg::RS_TERM));
  c_pad: cover property (@(posedge clk_sys) disable iff (rst) $rose(pad_detect_n_oe));
endmodule : ptt_top
`default_nettype wire

// ---- test/ptt_msg_partner.sv ----
// Purpose: message engine model on the transmitter side
// Assumes: a message is taken on valid and ready at a rising edge
// Notes:   stall sets how many cycles ready holds off
`timescale 1ns/1ps
`default_nettype none
module ptt_msg_partner (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] stall,
  input  wire logic       term_valid,
  output logic            term_ready,
  input  wire logic [7:0] term_code,
  input  wire logic       term_eoc,
  output logic      [7:0] last_code,
  output logic            last_eoc,
  output logic      [7:0] n_msg,
  output logic            hold_err
);
  logic [3:0] wait_q;
  logic [7:0] seen_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      term_ready <= 1'b0;
      wait_q     <= 4'h0;
      seen_q     <= 8'h00;
      last_code  <= 8'h00;
      last_eoc   <= 1'b0;
      n_msg      <= 8'h00;
      hold_err   <= 1'b0;
    end
    else if (term_valid && term_ready)
    begin
      term_ready <= 1'b0;
      wait_q     <= 4'h0;
      last_code  <= term_code;
      last_eoc   <= term_eoc;
      n_msg      <= n_msg + 8'h01;
    end
    else if (term_valid)
    begin
      // a slow engine exposes a code that drifts while waiting
      if (wait_q == 4'h0)
        seen_q <= term_code;
      else if (term_code !== seen_q)
        hold_err <= 1'b1;
      if (wait_q == stall)
        term_ready <= 1'b1;
      else
        wait_q <= wait_q + 4'h1;
    end
    else
      wait_q <= 4'h0;
  end
endmodule : ptt_msg_partner
`default_nettype wire

// ---- test/ptt_top_tb.sv ----
// Purpose: self-checking bench for the termination decision block
// Assumes: pin comparators driven as digital levels
// Notes:   one task per scenario, partner answers messages
`timescale 1ns/1ps
`default_nettype none
module ptt_top_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [12:0] cond_raw = 13'h0;
  logic        mode_pma = 1'b0, comm_active = 1'b0, err_pkt = 1'b0;
  logic        term_valid, term_ready, term_eoc, output_en, adapter_switch_en;
  logic [7:0]  term_code, last_code, n_msg, n0;
  logic        comm_limit_en, pd_o, pd_oe, boost_mode, adapter_status_out, last_eoc, hold_err;
  logic [1:0]  comm_limit_sel;
  logic [3:0]  stall = 4'h0;
  // no serial register interface on this bench: its clock and data lines count as grounded
  int          n_fail = 0, n_compared = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;

  ptt_top u_ptt_top (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cond_raw(cond_raw), .mode_pma(mode_pma), .comm_active(comm_active), .err_pkt(err_pkt),
    .term_valid(term_valid), .term_ready(term_ready), .term_code(term_code), .term_eoc(term_eoc),
    .output_en(output_en), .adapter_switch_en(adapter_switch_en), .comm_limit_en(comm_limit_en),
    .comm_limit_sel(comm_limit_sel), .pad_detect_n_o(pd_o), .pad_detect_n_oe(pd_oe),
    .boost_mode(boost_mode), .adapter_status_out(adapter_status_out));
  ptt_msg_partner u_ptt_msg_partner (.clk_sys(clk_sys), .rst(rst), .stall(stall), .term_valid(term_valid),
    .term_ready(term_ready), .term_code(term_code), .term_eoc(term_eoc), .last_code(last_code),
    .last_eoc(last_eoc), .n_msg(n_msg), .hold_err(hold_err));

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    // ceiling well above the several hundred cycles the tests need
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input int idx, input logic v);
    @(posedge clk_sys);
    cond_raw[idx] <= v;
  endtask : setc

  task automatic settle;
    repeat (4) @(posedge clk_sys);
  endtask : settle

  task automatic start(input logic md, input logic rectifier_node);
    @(posedge clk_sys);
    cond_raw <= 13'h0;
    mode_pma <= md;
    apb(1'b1, 32'h0, 32'h0);
    settle();
    apb(1'b1, 32'h0, 32'h1);
    settle();
    if (rectifier_node)
    begin
      setc(ptt_pkg::CB_RECTIFIER_NODE, 1'b1);
      for (int k = 0; k < 50 && output_en !== 1'b1; k++) @(posedge clk_sys);
      chk(output_en, 1, "output on");
    end
  endtask : start

  task automatic expect_msg(input logic [7:0] code, input logic eoc);
    n0 = n_msg;
    for (int k = 0; k < 200 && term_valid !== 1'b1; k++) @(posedge clk_sys);
    chk(output_en, 0, "output off before message");
    for (int k = 0; k < 200 && n_msg === n0; k++) @(posedge clk_sys);
    chk(last_code, code, "code");
    chk(last_eoc, eoc, "eoc");
    chk(hold_err, 0, "code held");
  endtask : expect_msg

  task automatic no_msg;
    n0 = n_msg;
    repeat (40) @(posedge clk_sys);
    chk(n_msg, n0, "no message");
  endtask : no_msg

  task automatic t_regs;
    chk(comm_limit_en, 1, "limit on at reset");
    apb(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h40, "errlim default");
    apb(1'b1, 32'hc, 32'h15);
    apb(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h15, "errlim write");
    apb(1'b1, 32'hc, 32'h40);
    apb(1'b0, 32'h10, 32'h0);
    chk(er, 1, "unmapped error");
    chk(rd, 0, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_startup;
    start(1'b0, 1'b0);
    // one short of the limit must stay quiet
    repeat (63)
    begin
      @(posedge clk_sys) err_pkt <= 1'b1;
      @(posedge clk_sys) err_pkt <= 1'b0;
    end
    no_msg();
    @(posedge clk_sys) err_pkt <= 1'b1;
    @(posedge clk_sys) err_pkt <= 1'b0;
    expect_msg(8'h04, 1'b0);
    $display("test startup done");
  endtask : t_startup

  task automatic t_adapter;
    start(1'b0, 1'b1);
    setc(ptt_pkg::CB_AD, 1'b1);
    expect_msg(8'h00, 1'b0);
    for (int k = 0; k < 20 && adapter_switch_en !== 1'b1; k++) @(posedge clk_sys);
    chk(adapter_switch_en, 1, "adapter switch");
    chk(adapter_status_out, 1, "adapter status");
    // two messages so far: startup timeout, then adapter with code 0x00 and no eoc
    apb(1'b0, 32'h8, 32'h0);
    chk(rd, 32'h0002_0000, "last message");
    $display("test adapter done");
  endtask : t_adapter

  task automatic t_codes;
    int          bit_t[5] = '{ptt_pkg::CB_CTRL_HI, ptt_pkg::CB_JHOT, ptt_pkg::CB_RLOW,
                              ptt_pkg::CB_TSHOT, ptt_pkg::CB_CTRL_LO};
    logic [7:0]  code_t[5] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h03};
    stall <= 4'h3;
    for (int i = 0; i < 5; i++)
    begin
      start(i[0], 1'b1);
      setc(bit_t[i], 1'b1);
      expect_msg(code_t[i], i[0]);
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_prio;
    start(1'b1, 1'b1);
    @(posedge clk_sys);
    cond_raw[ptt_pkg::CB_CTRL_HI] <= 1'b1;
    cond_raw[ptt_pkg::CB_JHOT] <= 1'b1;
    cond_raw[ptt_pkg::CB_TSHOT] <= 1'b1;
    expect_msg(8'h01, 1'b1);
    no_msg();
    $display("test priority done");
  endtask : t_prio

  task automatic t_term;
    stall <= 4'h0;
    start(1'b0, 1'b1);
    chk(boost_mode, 0, "boost off");
    setc(ptt_pkg::CB_TFIT, 1'b1);
    setc(ptt_pkg::CB_TERM, 1'b1);
    no_msg();
    chk(boost_mode, 1, "boost on");
    start(1'b1, 1'b1);
    setc(ptt_pkg::CB_TFIT, 1'b1);
    setc(ptt_pkg::CB_TERM, 1'b1);
    expect_msg(8'h01, 1'b1);
    $display("test term done");
  endtask : t_term

  task automatic t_pins;
    logic [1:0] sel_t[3] = '{ptt_pkg::LIM_NONE, ptt_pkg::LIM_PLUS, ptt_pkg::LIM_MINUS};
    start(1'b0, 1'b1);
    comm_active <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      cond_raw[ptt_pkg::CB_I100] <= (i > 0);
      cond_raw[ptt_pkg::CB_I400] <= (i > 1);
      settle();
      chk(comm_limit_sel, sel_t[i], "limit select");
    end
    setc(ptt_pkg::CB_LSEL, 1'b1);
    setc(ptt_pkg::CB_PMEM, 1'b1);
    settle();
    chk(comm_limit_en, 0, "limit off");
    chk({pd_oe, pd_o}, 2'h2, "pad detect low");
    setc(ptt_pkg::CB_LSEL, 1'b0);
    settle();
    chk(comm_limit_en, 1, "limit on");
    start(1'b1, 1'b1);
    cond_raw[ptt_pkg::CB_I100] <= 1'b1;
    cond_raw[ptt_pkg::CB_PMEM] <= 1'b1;
    settle();
    chk({pd_oe, comm_limit_sel}, 3'h0, "second standard pins");
    comm_active <= 1'b0;
    $display("test pins done");
  endtask : t_pins

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_startup();
    t_adapter();
    t_codes();
    t_prio();
    t_term();
    t_pins();
    tally_and_finish();
  end
endmodule : ptt_top_tb
`default_nettype wire
